// *** hw/poe_guard_pkg.sv ***
// Constants and carrier types of the power guard and indicator block.
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package poe_guard_pkg;

	// ---------------------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_NS = 1000000;
	localparam int MS_TICK_CYC = MS_NS / CLK_PERIOD_NS;
	localparam int PM_BLINK_MHZ = 400;
	localparam int OVL_BLINK_MHZ = 800;
	localparam int FAULT_BLINK_MHZ = 3300;
	localparam int MHZ_PER_KHZ_MS = 1000000;
	localparam int PM_HALF_MS = MHZ_PER_KHZ_MS / (2 * PM_BLINK_MHZ);
	localparam int OVL_HALF_MS = MHZ_PER_KHZ_MS / (2 * OVL_BLINK_MHZ);
	localparam int FAULT_HALF_MS = MHZ_PER_KHZ_MS / (2 * FAULT_BLINK_MHZ);
	localparam int SHED_MAX_S = 2;
	localparam int SHED_MAX_MS = SHED_MAX_S * 1000;
	// Excess in watts times delay in ms equals budget times this factor (one eighth of 1000).
	localparam logic [7:0] EXCESS_FACTOR = 8'h7d;

	// ---------------------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------------------
	localparam logic [7:0] BANK0_IDX = 8'h89;
	localparam logic [7:0] BANK7_IDX = 8'h90;
	localparam logic [7:0] MARGIN_IDX = 8'h9f;
	localparam logic [7:0] CTRL_IDX = 8'ha0;
	localparam logic [7:0] PRIO_IDX = 8'ha1;
	localparam logic [7:0] STATUS_IDX = 8'ha2;

	// ---------------------------------------------------------------------------
	// Reset values and fixed levels, in watts except CTRL_RST and PRIO_RST
	// ---------------------------------------------------------------------------
	localparam logic [7:0] BANK0_LOW_RST = 8'h90;
	localparam logic [7:0] BANK0_HIGH_RST = 8'hb0;
	localparam logic [7:0] BANK1_RST = 8'h8c;
	localparam logic [7:0] LEVEL_STEP = 8'h04;
	localparam logic [7:0] CONST_TOP = 8'h70;
	localparam logic [7:0] MARGIN_RST = 8'h14;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PRIO_RST = 8'he4;

	// ---------------------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------------------
	localparam int CTRL_HOST_SEL_BIT = 0;
	localparam int CTRL_LEVEL_LSB = 1;
	localparam int CTRL_FOUR_PAIR_BIT = 5;
	localparam int STAT_IND_BIT = 4;
	localparam int STAT_INTEG_BIT = 5;
	localparam int STAT_LEVEL_LSB = 6;
	localparam int STAT_TOTAL_LSB = 16;

	typedef struct packed {
		logic powered;
		logic overload;
		logic shorted;
		logic start_fail;
		logic underload;
	} port_status_t;

	typedef struct packed {
		logic supply_fault;
		logic over_temp;
	} chip_fault_t;

	typedef enum logic [2:0] {
		ST_CALM = 3'b001,
		ST_OVER = 3'b010,
		ST_DECAY = 3'b100
	} integ_state_t;

endpackage : poe_guard_pkg

// *** hw/poe_power_guard.sv ***
// Power guard, load shedding and indicator drive with an AHB-Lite register slave.
`timescale 1ns/1ps
module poe_power_guard #(
	parameter int TICK_CYC = poe_guard_pkg::MS_TICK_CYC,
	parameter int PORTS = 4
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Port monitor, same clock domain
	input wire logic [PORTS-1:0][7:0] port_power,
	input wire poe_guard_pkg::port_status_t [PORTS-1:0] port_status,
	input wire poe_guard_pkg::chip_fault_t chip_fault,
	// Straps and select pins
	input wire logic [3:0] budget_select,
	input wire logic at_high_mode,
	// Indicators and shedding
	output logic [PORTS-1:0] port_indicator,
	output logic budget_indicator,
	output logic [PORTS-1:0] port_shed
);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ---------------------------------------------------------------------------
	// Millisecond tick and blink phases
	// ---------------------------------------------------------------------------
	localparam int TW = $clog2(TICK_CYC + 1);
	localparam int HALF_MS [3] = '{poe_guard_pkg::PM_HALF_MS, poe_guard_pkg::OVL_HALF_MS,
		poe_guard_pkg::FAULT_HALF_MS};
	logic [TW-1:0] tick_cnt_q, tick_cnt_d;
	logic tick_q, tick_d;
	logic [2:0] blink_q;

	always_comb begin
		tick_d = 1'b0;
		tick_cnt_d = tick_cnt_q + TW'(1);
		if (tick_cnt_q == TW'(TICK_CYC - 1)) begin
			tick_cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	for (genvar r = 0; r < 3; r++) begin : g_blink
		logic [11:0] cnt_q, cnt_d;
		logic ph_d;
		always_comb begin
			cnt_d = cnt_q;
			ph_d = blink_q[r];
			if (tick_q) begin
				if (cnt_q == 12'(HALF_MS[r] - 1)) begin
					cnt_d = '0;
					ph_d = ~blink_q[r];
				end else begin
					cnt_d = cnt_q + 12'h001;
				end
			end
		end
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				cnt_q <= '0;
				blink_q[r] <= 1'b0;
			end else begin
				cnt_q <= cnt_d;
				blink_q[r] <= ph_d;
			end
		end
	end

	wire pm_ph = blink_q[0];
	wire ovl_ph = blink_q[1];
	wire fault_ph = blink_q[2];

	// ---------------------------------------------------------------------------
	// Pin synchronisers for the select pins and the mode strap
	// ---------------------------------------------------------------------------
	logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q;
	logic [3:0] sel_q, sel_d;
	logic [2:0] init_cnt_q, init_cnt_d;

	always_comb begin
		sel_d = sel_q;
		if (pin_s2_q[3:0] == pin_s3_q[3:0]) begin
			sel_d = pin_s3_q[3:0];
		end
		init_cnt_d = init_cnt_q;
		if (init_cnt_q != 3'h4) begin
			init_cnt_d = init_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			sel_q <= '0;
			init_cnt_q <= '0;
		end else begin
			pin_s1_q <= {at_high_mode, budget_select};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			sel_q <= sel_d;
			init_cnt_q <= init_cnt_d;
		end
	end

	// ---------------------------------------------------------------------------
	// AHB-Lite slave and register file
	// ---------------------------------------------------------------------------
	logic [7:0] bank_q [8];
	logic [7:0] bank_d [8];
	logic [7:0] margin_q, margin_d, ctrl_q, ctrl_d, prio_q, prio_d;
	logic wr_pend_q, wr_pend_d;
	logic [7:0] wr_idx_q, wr_idx_d;
	logic [31:0] rdata_d, hrdata_q;
	logic [PORTS-1:0] shed_q, shed_d, shed_set, shed_clr;
	logic ind_q, ind_d;
	logic [PORTS-1:0] led_q, led_d;
	logic [3:0] level_q, level_d;
	logic [7:0] budget_q, budget_d;
	logic [9:0] total_q, total_d;
	logic [16:0] acc_q, acc_d;

	wire addr_ok = haddr[31:10] == 22'h000000;
	wire [7:0] a_idx = haddr[9:2];
	wire take = hsel && htrans[1] && hready && addr_ok && hsize == 3'h2;
	wire four_pair = ctrl_q[poe_guard_pkg::CTRL_FOUR_PAIR_BIT];

	always_comb begin
		bank_d = bank_q;
		margin_d = margin_q;
		ctrl_d = ctrl_q;
		prio_d = prio_q;
		shed_clr = '0;
		wr_pend_d = take && hwrite;
		wr_idx_d = a_idx;
		rdata_d = hrdata_q;
		// The strap is taken once, when the second and third flops both hold it.
		if (init_cnt_q == 3'h3 && pin_s2_q[4] && pin_s3_q[4]) begin
			bank_d[0] = poe_guard_pkg::BANK0_HIGH_RST;
		end
		if (wr_pend_q) begin
			if (wr_idx_q >= poe_guard_pkg::BANK0_IDX && wr_idx_q <= poe_guard_pkg::BANK7_IDX) begin
				bank_d[3'(wr_idx_q - poe_guard_pkg::BANK0_IDX)] = hwdata[7:0];
			end
			case (wr_idx_q)
				poe_guard_pkg::MARGIN_IDX: margin_d = hwdata[7:0];
				poe_guard_pkg::CTRL_IDX: ctrl_d = hwdata[7:0];
				poe_guard_pkg::PRIO_IDX: prio_d = hwdata[7:0];
				poe_guard_pkg::STATUS_IDX: shed_clr = hwdata[PORTS-1:0];
				default: ;
			endcase
		end
		if (take && !hwrite) begin
			rdata_d = '0;
			if (a_idx >= poe_guard_pkg::BANK0_IDX && a_idx <= poe_guard_pkg::BANK7_IDX) begin
				rdata_d[7:0] = bank_q[3'(a_idx - poe_guard_pkg::BANK0_IDX)];
			end
			case (a_idx)
				poe_guard_pkg::MARGIN_IDX: rdata_d[7:0] = margin_q;
				poe_guard_pkg::CTRL_IDX: rdata_d[7:0] = ctrl_q;
				poe_guard_pkg::PRIO_IDX: rdata_d[7:0] = prio_q;
				poe_guard_pkg::STATUS_IDX: begin
					rdata_d[PORTS-1:0] = shed_q;
					rdata_d[poe_guard_pkg::STAT_IND_BIT] = acc_q != '0;
					rdata_d[poe_guard_pkg::STAT_INTEG_BIT] = total_q > {2'b00, budget_q};
					rdata_d[poe_guard_pkg::STAT_LEVEL_LSB +: 4] = level_q;
					rdata_d[poe_guard_pkg::STAT_TOTAL_LSB +: 10] = total_q;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bank_q[0] <= poe_guard_pkg::BANK0_LOW_RST;
			for (int i = 1; i < 8; i++) begin
				bank_q[i] <= poe_guard_pkg::BANK1_RST - 8'(poe_guard_pkg::LEVEL_STEP * (i - 1));
			end
			margin_q <= poe_guard_pkg::MARGIN_RST;
			ctrl_q <= poe_guard_pkg::CTRL_RST;
			prio_q <= poe_guard_pkg::PRIO_RST;
			wr_pend_q <= 1'b0;
			wr_idx_q <= '0;
			hrdata_q <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			bank_q <= bank_d;
			margin_q <= margin_d;
			ctrl_q <= ctrl_d;
			prio_q <= prio_d;
			wr_pend_q <= wr_pend_d;
			wr_idx_q <= wr_idx_d;
			hrdata_q <= rdata_d;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;

	// ---------------------------------------------------------------------------
	// Budget selection and total power
	// ---------------------------------------------------------------------------
	always_comb begin
		level_d = ctrl_q[poe_guard_pkg::CTRL_HOST_SEL_BIT] ? ctrl_q[poe_guard_pkg::CTRL_LEVEL_LSB +: 4] : sel_q;
		if (level_d[3]) begin
			budget_d = poe_guard_pkg::CONST_TOP - {3'b000, level_d[2:0], 2'b00};
		end else begin
			budget_d = bank_q[level_d[2:0]];
		end
		total_d = '0;
		for (int i = 0; i < PORTS; i++) begin
			if (port_status[i].powered && !shed_q[i]) begin
				total_d = total_d + {2'b00, port_power[i]};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_q <= '0;
			budget_q <= poe_guard_pkg::BANK0_LOW_RST;
			total_q <= '0;
		end else begin
			level_q <= level_d;
			budget_q <= budget_d;
			total_q <= total_d;
		end
	end

	// ---------------------------------------------------------------------------
	// Power integrator and port shedding
	// ---------------------------------------------------------------------------
	poe_guard_pkg::integ_state_t st_q, st_d;
	logic [11:0] ms_q, ms_d;
	logic [PORTS-1:0] victim;
	wire over = total_q > {2'b00, budget_q};
	wire [9:0] excess = total_q - {2'b00, budget_q};
	wire [9:0] deficit = {2'b00, budget_q} - total_q;
	wire [16:0] limit = 17'(budget_q * poe_guard_pkg::EXCESS_FACTOR);
	wire [16:0] acc_sum = acc_q + {7'h00, excess};

	always_comb begin
		logic [1:0] best;
		logic found;
		best = '0;
		found = 1'b0;
		victim = '0;
		for (int i = 0; i < PORTS; i++) begin
			if (port_status[i].powered && !shed_q[i] && (!found || prio_q[2*i +: 2] >= best)) begin
				found = 1'b1;
				best = prio_q[2*i +: 2];
				victim = PORTS'(1) << i;
			end
		end
	end

	always_comb begin
		st_d = st_q;
		acc_d = acc_q;
		ms_d = ms_q;
		shed_set = '0;
		case (st_q)
			poe_guard_pkg::ST_CALM: begin
				if (over) begin
					st_d = poe_guard_pkg::ST_OVER;
				end
			end
			poe_guard_pkg::ST_OVER: begin
				if (!over) begin
					st_d = poe_guard_pkg::ST_DECAY;
				end else if (tick_q) begin
					if (acc_sum > limit || ms_q == 12'(poe_guard_pkg::SHED_MAX_MS - 1)) begin
						shed_set = victim;
						acc_d = '0;
						ms_d = '0;
						st_d = poe_guard_pkg::ST_CALM;
					end else begin
						acc_d = acc_sum;
						ms_d = ms_q + 12'h001;
					end
				end
			end
			poe_guard_pkg::ST_DECAY: begin
				if (over) begin
					st_d = poe_guard_pkg::ST_OVER;
				end else if (tick_q) begin
					if (acc_q <= {7'h00, deficit}) begin
						acc_d = '0;
						ms_d = '0;
						st_d = poe_guard_pkg::ST_CALM;
					end else begin
						acc_d = acc_q - {7'h00, deficit};
					end
				end
			end
			default: st_d = poe_guard_pkg::ST_CALM;
		endcase
		shed_d = (shed_q & ~shed_clr) | shed_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= poe_guard_pkg::ST_CALM;
			acc_q <= '0;
			ms_q <= '0;
			shed_q <= '0;
		end else begin
			st_q <= st_d;
			acc_q <= acc_d;
			ms_q <= ms_d;
			shed_q <= shed_d;
		end
	end

	assign port_shed = shed_q;

	// ---------------------------------------------------------------------------
	// Indicators
	// ---------------------------------------------------------------------------
	wire [8:0] floor_w = {1'b0, budget_q} - {1'b0, margin_q};
	wire above_guard = margin_q > budget_q || total_q > {1'b0, floor_w};
	wire any_fault = chip_fault.supply_fault || chip_fault.over_temp;

	always_comb begin
		if (over || acc_q != '0) begin
			ind_d = pm_ph;
		end else begin
			ind_d = above_guard && shed_q == '0;
		end
	end

	for (genvar p = 0; p < PORTS; p++) begin : g_led
		always_comb begin
			if (four_pair && p % 2 == 0) begin
				led_d[p] = 1'b0;
			end else if (any_fault) begin
				led_d[p] = fault_ph;
			end else if (shed_q[p]) begin
				led_d[p] = pm_ph;
			end else if (port_status[p].overload || port_status[p].shorted || port_status[p].start_fail) begin
				led_d[p] = ovl_ph;
			end else if (four_pair && port_status[p].underload) begin
				led_d[p] = pm_ph;
			end else begin
				led_d[p] = port_status[p].powered;
			end
		end
		a_shed_led_blinks: assert property ((shed_q[p] && !any_fault && !(four_pair && p % 2 == 0))
			|=> port_indicator[p] == $past(pm_ph)) else $error("shed port indicator not blinking");
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ind_q <= 1'b0;
			led_q <= '0;
		end else begin
			ind_q <= ind_d;
			led_q <= led_d;
		end
	end

	assign budget_indicator = ind_q;
	assign port_indicator = led_q;

	// ---------------------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------------------
	sequence s_calm_low;
		!over && acc_q == '0 && !above_guard;
	endsequence
	sequence s_over_entry;
		st_q == poe_guard_pkg::ST_CALM && over;
	endsequence
	sequence s_shed_due;
		st_q == poe_guard_pkg::ST_OVER && over && tick_q && acc_sum > limit && victim != '0;
	endsequence

	a_guard_dark: assert property (s_calm_low |=> !budget_indicator)
		else $error("budget indicator lit below margin");
	a_guard_steady: assert property ((!over && acc_q == '0 && above_guard && shed_q == '0) [*2]
		|-> budget_indicator) else $error("budget indicator not steady");
	a_over_blink: assert property (over |=> budget_indicator == $past(pm_ph))
		else $error("budget indicator not blinking above budget");
	a_total_sum: assert property ((shed_q == '1) |=> total_q == '0)
		else $error("shed ports still counted in total");
	a_integ_start: assert property (s_over_entry |=> st_q == poe_guard_pkg::ST_OVER ##1 st_q != poe_guard_pkg::ST_CALM
		|| !$past(over)) else $error("integrator did not start");
	a_shed_fire: assert property (s_shed_due |=> (shed_q & ~$past(shed_q)) != '0 && acc_q == '0)
		else $error("lowest priority port not shed");
	a_shed_cap: assert property (ms_q < 12'(poe_guard_pkg::SHED_MAX_MS))
		else $error("shedding delay above cap");
	a_fault_all: assert property (any_fault && !four_pair |=> port_indicator == {PORTS{$past(fault_ph)}})
		else $error("fault blink not common");
	a_pair_unused: assert property (four_pair |=> port_indicator[0] == 1'b0 && port_indicator[2] == 1'b0)
		else $error("unused indicator driven");
	a_const_level: assert property (level_q[3] |-> budget_q == poe_guard_pkg::CONST_TOP
		- {3'b000, level_q[2:0], 2'b00}) else $error("constant budget level wrong");
	a_select_follow: assert property ((!ctrl_q[0] && pin_s2_q[3:0] == pin_s3_q[3:0]) ##1 !ctrl_q[0]
		|=> level_q == $past(pin_s3_q[3:0], 2)) else $error("select change not applied");

endmodule : poe_power_guard

// *** verif/poe_strap_led_model.sv ***
// Model of the select straps and the indicator LEDs beside the power guard block.
`timescale 1ns/1ps
module poe_strap_led_model (
	// Clock
	input wire logic hclk,
	// Requests from the bench
	input wire logic [3:0] code_req,
	input wire logic high_req,
	input wire logic watch_clr,
	// Pins to and from the device
	output logic [3:0] budget_select,
	output logic at_high_mode,
	input wire logic [3:0] port_indicator,
	// LED levels seen since the last clear
	output logic [3:0] lit_seen,
	output logic [3:0] dark_seen
);
	// Straps are plain levels; a change reaches the pins at once.
	assign budget_select = code_req;
	assign at_high_mode = high_req;

	always_ff @(posedge hclk) begin
		lit_seen <= watch_clr ? 4'h0 : lit_seen | port_indicator;
		dark_seen <= watch_clr ? 4'h0 : dark_seen | ~port_indicator;
	end
endmodule : poe_strap_led_model

// *** verif/poe_power_guard_tb.sv ***
// Self-checking testbench of the power guard and indicator block.
`timescale 1ns/1ps
module poe_power_guard_tb;
	localparam int TICK = 10;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic [3:0][7:0] port_power = 32'h0;
	poe_guard_pkg::port_status_t [3:0] port_status = 20'h84210;
	poe_guard_pkg::chip_fault_t chip_fault = 2'h0;
	logic [3:0] code_req = 4'h0;
	logic high_req = 1'b1;
	logic watch_clr = 1'b1;
	logic [3:0] budget_select;
	logic at_high_mode;
	logic [3:0] port_indicator;
	logic [3:0] port_shed;
	logic budget_indicator;
	logic [3:0] lit_seen;
	logic [3:0] dark_seen;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int seed = 32'h1dc8;
	int b;
	logic [31:0] rd;
	logic [7:0] lvl [8];
	logic [7:0] m;

	initial begin
		forever #2.5 hclk = ~hclk;
	end

	poe_power_guard #(.TICK_CYC(TICK), .PORTS(4)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .port_power(port_power), .port_status(port_status),
		.chip_fault(chip_fault), .budget_select(budget_select), .at_high_mode(at_high_mode),
		.port_indicator(port_indicator), .budget_indicator(budget_indicator), .port_shed(port_shed));

	poe_strap_led_model i_partner (.hclk(hclk), .code_req(code_req), .high_req(high_req), .watch_clr(watch_clr),
		.budget_select(budget_select), .at_high_mode(at_high_mode), .port_indicator(port_indicator),
		.lit_seen(lit_seen), .dark_seen(dark_seen));

	// ---------------------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic set_total(input int t);
		int q;
		q = t / 4;
		port_power <= {8'(q), 8'(q), 8'(q), 8'(t - 3 * q)};
	endtask : set_total

	task automatic watch(input int n);
		watch_clr <= 1'b1;
		@(posedge hclk);
		watch_clr <= 1'b0;
		repeat (n) @(posedge hclk);
	endtask : watch

	function automatic int budget_of(input int code);
		return code < 8 ? int'(lvl[code]) : 112 - 4 * (code - 8);
	endfunction : budget_of

	function automatic int shed_ticks(input int bud, input int ex);
		return (bud * 125 / ex < 2000) ? bud * 125 / ex : 2000;
	endfunction : shed_ticks

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			report_and_stop();
		end
	end

	// ---------------------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------------------
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, poe_guard_pkg::BANK0_IDX + 8'(i), 32'h0);
			check(rd, 32'(i == 0 ? 8'hb0 : 8'(144 - 4 * i)));
		end
		bus(1'b0, poe_guard_pkg::MARGIN_IDX, 32'h0);
		check(rd, 32'h14);
		bus(1'b0, poe_guard_pkg::PRIO_IDX, 32'h0);
		check(rd, 32'he4);
		bus(1'b1, 8'h91, 32'($random(seed)));
		bus(1'b0, 8'h91, 32'h0);
		check(rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			lvl[i] = 8'(32 + ($random(seed) & 127));
			bus(1'b1, poe_guard_pkg::BANK0_IDX + 8'(i), {24'h0, lvl[i]});
			bus(1'b0, poe_guard_pkg::BANK0_IDX + 8'(i), 32'h0);
			check(rd, {24'h0, lvl[i]});
		end
		m = 8'(1 + ($random(seed) & 15));
		bus(1'b1, poe_guard_pkg::MARGIN_IDX, {24'h0, m});
		bus(1'b0, poe_guard_pkg::MARGIN_IDX, 32'h0);
		check(rd, {24'h0, m});
		$display("Test registers finished");
		// Every select code, then the host choosing the lowest constant.
		for (int c = 0; c < 17; c++) begin
			set_total(0);
			if (c < 16) begin
				code_req <= 4'(c);
			end else begin
				bus(1'b1, poe_guard_pkg::CTRL_IDX, 32'h1f);
			end
			b = budget_of(c < 16 ? c : 15);
			repeat (10) @(posedge hclk);
			set_total(b - int'(m));
			repeat (4) @(posedge hclk);
			check(32'(budget_indicator), 32'h0);
			set_total(b - int'(m) + 1);
			repeat (4) @(posedge hclk);
			check(32'(budget_indicator), 32'h1);
			set_total(b);
			repeat (4) @(posedge hclk);
			check(32'(budget_indicator), 32'h1);
		end
		bus(1'b1, poe_guard_pkg::CTRL_IDX, 32'h0);
		code_req <= 4'h8;
		repeat (10) @(posedge hclk);
		$display("Test thresholds finished");
		// Excess of 100 W over a 112 W budget; port 3 has the lowest priority.
		port_power <= {8'd112, 8'd34, 8'd33, 8'd33};
		repeat ((shed_ticks(112, 100) - 5) * TICK) @(posedge hclk);
		check(32'(port_shed), 32'h0);
		bus(1'b0, poe_guard_pkg::STATUS_IDX, 32'h0);
		check(32'(rd[5:4]), 32'h3);
		repeat (10 * TICK) @(posedge hclk);
		check(32'(port_shed), 32'h8);
		repeat (4) @(posedge hclk);
		check(32'(budget_indicator), 32'h0);
		bus(1'b0, poe_guard_pkg::STATUS_IDX, 32'h0);
		check(32'(rd[25:16]), 32'd100);
		port_power <= {8'd0, 8'd34, 8'd33, 8'd33};
		bus(1'b1, poe_guard_pkg::STATUS_IDX, 32'hf);
		repeat (4) @(posedge hclk);
		check(32'(budget_indicator), 32'(100 > 112 - int'(m)));
		// One watt of excess waits for the two second ceiling.
		port_power <= {8'd13, 8'd34, 8'd33, 8'd33};
		repeat ((shed_ticks(112, 1) - 5) * TICK) @(posedge hclk);
		check(32'(port_shed), 32'h0);
		repeat (10 * TICK) @(posedge hclk);
		check(32'(port_shed), 32'h8);
		set_total(0);
		bus(1'b1, poe_guard_pkg::STATUS_IDX, 32'hf);
		$display("Test shedding finished");
		for (int f = 1; f < 3; f++) begin
			chip_fault <= 2'(f);
			watch(3100);
			check({lit_seen, dark_seen}, 32'hff);
			check(32'(&port_indicator | ~|port_indicator), 32'h1);
		end
		chip_fault <= 2'h0;
		bus(1'b1, poe_guard_pkg::CTRL_IDX, 32'h20);
		port_status <= {5'b11000, 5'b10000, 5'b10001, 5'b10000};
		watch(25100);
		check({lit_seen, dark_seen}, 32'haf);
		bus(1'b1, poe_guard_pkg::CTRL_IDX, 32'h0);
		port_status <= {5'b10000, 5'b00000, 5'b10001, 5'b11000};
		watch(12600);
		check({lit_seen, dark_seen}, 32'hb5);
		$display("Test indicators finished");
		report_and_stop();
	end
endmodule : poe_power_guard_tb
